/* File: design/port_input_defines.svh */
/*
  Offsets, opcodes, field positions and T-state counts of the port input block.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef PORT_INPUT_DEFINES_SVH
`define PORT_INPUT_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define OFS_CMD        32'h0000_0000
`define OFS_STATUS     32'h0000_0004
`define OFS_BC         32'h0000_0008
`define OFS_DE         32'h0000_000c
`define OFS_PTR        32'h0000_0010
`define OFS_AF         32'h0000_0014
`define OFS_PC         32'h0000_0018
`define IDX_NONE       3'h0
`define IDX_CMD        3'h1
`define IDX_STATUS     3'h2
`define IDX_BC         3'h3
`define IDX_DE         3'h4
`define IDX_PTR        3'h5
`define IDX_AF         3'h6
`define IDX_PC         3'h7
`define ST_BUSY        0
`define ST_DONE        1
`define ST_ILLEGAL     2
`define ST_INTR        3

// ----------------------------------------------------------------
// Opcodes and fields
// ----------------------------------------------------------------
`define OP_PREFIX      8'hed
`define OP_UP_SINGLE   8'ha2
`define OP_UP_REPEAT   8'hb2
`define OP_DN_SINGLE   8'haa
`define OP_DN_REPEAT   8'hba
`define OP_REG_MASK    8'hc7
`define OP_REG_VAL     8'h40
`define DEST_B         3'h0
`define DEST_C         3'h1
`define DEST_D         3'h2
`define DEST_E         3'h3
`define DEST_H         3'h4
`define DEST_L         3'h5
`define DEST_FLAGS     3'h6
`define DEST_A         3'h7
`define FLG_S          7
`define FLG_Z          6
`define FLG_H          4
`define FLG_PV         2
`define FLG_N          1
`define FLG_C          0

// ----------------------------------------------------------------
// Timing in T states
// ----------------------------------------------------------------
`define T_IN_REG       5'h0c
`define T_BLK_LAST     5'h10
`define T_BLK_CONT     5'h15
`define REFRESH_COUNT  2'h2

`endif

/* File: design/port_input_pkg.sv */
/*
  Types shared by the port input block and its flag_unit helper.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package port_input_pkg;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_PORT  = 3'b001,
    S_PUSH  = 3'b010,
    S_DRAIN = 3'b011,
    S_UPD   = 3'b100,
    S_WAIT  = 3'b101
  } state_e;

  typedef enum logic [1:0] {
    FM_KEEP   = 2'b00,
    FM_IN_REG = 2'b01,
    FM_BLOCK  = 2'b10
  } flag_mode_e;

  typedef struct packed {
    logic valid;
    logic reg_form;
    logic up;
    logic rep;
  } op_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_word_s;

endpackage

/* File: design/flag_unit.sv */
/*
  Condition flag update for port input and block input.
  Assumes flag positions from the defines header; purely combinational.
*/
`include "port_input_defines.svh"

module flag_unit import port_input_pkg::*; (
  input  wire flag_mode_e mode,
  input  wire logic [7:0] data,
  input  wire logic [7:0] b_dec,
  input  wire logic [7:0] f_old,
  output logic      [7:0] f_new
);

  always_comb begin
    f_new = f_old;
    case (mode)
      FM_IN_REG: begin
        f_new[`FLG_S]  = data[7];
        f_new[`FLG_Z]  = (data == 8'h00);
        f_new[`FLG_H]  = 1'b0;
        f_new[`FLG_PV] = ~^data;
        f_new[`FLG_N]  = 1'b0;
      end
      FM_BLOCK: begin
        // Sign, half-carry and parity left as they were
        f_new[`FLG_Z] = (b_dec == 8'h00);
        f_new[`FLG_N] = 1'b1;
      end
      default: f_new = f_old;
    endcase
  end

endmodule // flag_unit

/* File: design/two_entry_buffer.sv */
/*
  Two-entry buffer with valid and ready on both sides; out_valid and out_data are registers, in_ready is decoded from skid_valid, empty from both valids.
  Assumes one clock and a synchronous active-high reset.
*/
module two_entry_buffer #(
  parameter int W = 24
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data,
  output logic              empty
);

  logic         skid_valid;
  logic [W-1:0] skid_data;
  logic         push;
  logic         pop;

  assign in_ready = ~skid_valid;
  assign push     = in_valid & ~skid_valid;
  assign pop      = out_valid & out_ready;
  assign empty    = ~out_valid & ~skid_valid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_valid  <= 1'b0;
      out_data   <= '0;
      skid_valid <= 1'b0;
      skid_data  <= '0;
    end else if (pop || !out_valid) begin
      if (skid_valid) begin
        out_data   <= skid_data;
        out_valid  <= 1'b1;
        skid_valid <= 1'b0;
      end else begin
        out_valid <= push;
        out_data  <= in_data;
      end
    end else if (push) begin
      skid_valid <= 1'b1;
      skid_data  <= in_data;
    end
  end

endmodule // two_entry_buffer

/* File: design/port_input_block_transfer.sv */
/*
  Execution engine for port input: single register input and block input
  to memory, single or repeating, up or down. Software loads the registers
  and issues the two opcode bytes over AHB-Lite.
  Assumes a port peripheral answering io_rd with io_ack and a memory
  taking each word on mem_wr with mem_ack; all inputs synchronous to sys_clk.
*/
// Overview of operation
// (RL1) Register input field picks B, C, D, E, H, L or A.
// (RL2) Port read drives C on low address and B on high address.
// (RL3) Peripheral supplies a byte; register input stores it in the chosen register.
// (RL4) Register input sets S, Z, even parity; clears H, N; keeps carry.
// (RL5) Field 110 writes no register, only updates flags.
// (RL6) Up form writes the byte at the pointer, then decrements B, increments pointer.
// (RL7) Down forms write the byte then decrement both B and pointer.
// (RL8) Single block form sets Z when new B is zero, sets N, keeps carry.
// (RL9) Repeat form with nonzero B moves PC back two; stops at zero.
// (RL10) Between repeats take pending interrupts and run two refresh cycles.
// (RL11) B of zero at start of a repeat moves 256 bytes.
// (RL12) Continuing iteration lasts 21 T states, final one 16.
// (RL13) Opcode is prefix ED then A2, B2, AA or BA.
// (RL14) Finished repeat leaves Z and N set, carry kept.
`include "port_input_defines.svh"

module port_input_block_transfer import port_input_pkg::*; #(
  parameter int T_DIV = 1
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [15:0] io_addr,
  output logic             io_rd,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_ack,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_wr,
  input  wire logic        mem_ack,
  output logic             refresh,
  input  wire logic        irq_pending,
  output logic             irq_taken
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  b_reg, c_reg, d_reg, e_reg, h_reg, l_reg, a_reg, f_reg;
  logic [15:0] pc_reg;
  state_e      state_reg;
  op_s         op_reg;
  op_s         op_next;
  logic [2:0]  dest_reg;
  logic [7:0]  in_byte_reg;
  logic [4:0]  tcnt_reg;
  logic [4:0]  target_reg;
  logic [1:0]  ref_left_reg;
  logic        cont_reg;
  logic        done_reg, illegal_reg, intr_reg;
  logic [7:0]  div_reg;
  logic        t_tick_reg;
  logic        wr_pend_reg;
  logic [2:0]  wr_idx_reg;
  logic        busy;
  logic        cmd_fire;
  logic        aphase;
  logic [7:0]  b_dec;
  logic [15:0] ptr_next;
  logic        cont_next;
  flag_mode_e  fmode;
  logic [7:0]  f_new;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        buf_empty;
  mem_word_s   buf_in;
  mem_word_s   buf_out;

  assign busy      = (state_reg != S_IDLE);
  assign aphase    = hsel && htrans[1] && hready;
  assign cmd_fire  = wr_pend_reg && (wr_idx_reg == `IDX_CMD) && !busy;
  assign b_dec     = b_reg - 8'h01;
  assign ptr_next  = op_reg.up ? {h_reg, l_reg} + 16'h0001 : {h_reg, l_reg} - 16'h0001; // RL6 RL7
  assign cont_next = op_reg.rep && (b_dec != 8'h00); // RL9 RL11
  assign op_next   = decode_op(hwdata[15:0]);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [31:0] a);
    case (a)
      `OFS_CMD:    reg_index = `IDX_CMD;
      `OFS_STATUS: reg_index = `IDX_STATUS;
      `OFS_BC:     reg_index = `IDX_BC;
      `OFS_DE:     reg_index = `IDX_DE;
      `OFS_PTR:    reg_index = `IDX_PTR;
      `OFS_AF:     reg_index = `IDX_AF;
      `OFS_PC:     reg_index = `IDX_PC;
      default:     reg_index = `IDX_NONE;
    endcase
  endfunction

  // Low byte is the prefix, high byte the second opcode byte
  function automatic op_s decode_op(input logic [15:0] cmd);
    op_s o;
    o = '0;
    if (cmd[7:0] == `OP_PREFIX) begin // RL13
      if ((cmd[15:8] & `OP_REG_MASK) == `OP_REG_VAL) begin
        o.valid    = 1'b1;
        o.reg_form = 1'b1;
      end else begin
        case (cmd[15:8])
          `OP_UP_SINGLE: o = '{valid: 1'b1, reg_form: 1'b0, up: 1'b1, rep: 1'b0};
          `OP_UP_REPEAT: o = '{valid: 1'b1, reg_form: 1'b0, up: 1'b1, rep: 1'b1};
          `OP_DN_SINGLE: o = '{valid: 1'b1, reg_form: 1'b0, up: 1'b0, rep: 1'b0};
          `OP_DN_REPEAT: o = '{valid: 1'b1, reg_form: 1'b0, up: 1'b0, rep: 1'b1};
          default:       o = '0;
        endcase
      end
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= `IDX_NONE;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= aphase && hwrite;
      wr_idx_reg  <= reg_index(haddr);
      if (aphase && !hwrite) begin
        case (reg_index(haddr))
          `IDX_STATUS: hrdata <= {28'h0000000, intr_reg, illegal_reg, done_reg, busy};
          `IDX_BC:     hrdata <= {16'h0000, b_reg, c_reg};
          `IDX_DE:     hrdata <= {16'h0000, d_reg, e_reg};
          `IDX_PTR:    hrdata <= {16'h0000, h_reg, l_reg};
          `IDX_AF:     hrdata <= {16'h0000, a_reg, f_reg};
          `IDX_PC:     hrdata <= {16'h0000, pc_reg};
          default:     hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // T-state divider
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_reg    <= 8'h00;
      t_tick_reg <= 1'b0;
    end else if (div_reg == 8'(T_DIV - 1)) begin
      div_reg    <= 8'h00;
      t_tick_reg <= 1'b1;
    end else begin
      div_reg    <= div_reg + 8'h01;
      t_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register file: software writes while idle, engine updates while busy
  // ----------------------------------------------------------------
  assign fmode = (state_reg == S_PORT && io_ack && op_reg.reg_form) ? FM_IN_REG :
                 (state_reg == S_UPD) ? FM_BLOCK : FM_KEEP;

  flag_unit u_flags (
    .mode  (fmode),
    .data  (io_rdata),
    .b_dec (b_dec),
    .f_old (f_reg),
    .f_new (f_new)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {b_reg, c_reg, d_reg, e_reg} <= 32'h0000_0000;
      {h_reg, l_reg, a_reg, f_reg} <= 32'h0000_0000;
      pc_reg <= 16'h0000;
    end else if (wr_pend_reg && !busy) begin
      case (wr_idx_reg)
        `IDX_BC: {b_reg, c_reg} <= hwdata[15:0];
        `IDX_DE: {d_reg, e_reg} <= hwdata[15:0];
        `IDX_PTR: {h_reg, l_reg} <= hwdata[15:0];
        `IDX_AF: {a_reg, f_reg} <= hwdata[15:0];
        `IDX_PC: pc_reg <= hwdata[15:0];
        default: ;
      endcase
    end else if (state_reg == S_PORT && io_ack && op_reg.reg_form) begin
      f_reg <= f_new; // RL4
      case (dest_reg) // RL1 RL3
        `DEST_B: b_reg <= io_rdata;
        `DEST_C: c_reg <= io_rdata;
        `DEST_D: d_reg <= io_rdata;
        `DEST_E: e_reg <= io_rdata;
        `DEST_H: h_reg <= io_rdata;
        `DEST_L: l_reg <= io_rdata;
        `DEST_A: a_reg <= io_rdata;
        default: ; // RL5
      endcase
    end else if (state_reg == S_UPD) begin
      b_reg          <= b_dec; // RL6 RL7
      {h_reg, l_reg} <= ptr_next;
      f_reg          <= f_new; // RL8 RL14
      if (cont_next) begin
        pc_reg <= pc_reg - 16'h0002; // RL9
      end
    end
  end

  // ----------------------------------------------------------------
  // Data path to memory
  // ----------------------------------------------------------------
  assign buf_in_valid = (state_reg == S_PUSH);
  assign buf_in       = '{addr: {h_reg, l_reg}, data: in_byte_reg}; // RL6
  assign mem_addr     = buf_out.addr;
  assign mem_wdata    = buf_out.data;

  two_entry_buffer #(
    .W ($bits(mem_word_s))
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (mem_wr),
    .out_ready (mem_ack),
    .out_data  (buf_out),
    .empty     (buf_empty)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg    <= S_IDLE;
      op_reg       <= '0;
      dest_reg     <= `DEST_B;
      in_byte_reg  <= 8'h00;
      io_rd        <= 1'b0;
      io_addr      <= 16'h0000;
      tcnt_reg     <= 5'h00;
      target_reg   <= 5'h00;
      ref_left_reg <= 2'h0;
      cont_reg     <= 1'b0;
      done_reg     <= 1'b0;
      illegal_reg  <= 1'b0;
      intr_reg     <= 1'b0;
      irq_taken    <= 1'b0;
      refresh      <= 1'b0;
    end else begin
      irq_taken <= 1'b0;
      refresh   <= 1'b0;
      if (t_tick_reg && tcnt_reg != 5'h1f) begin
        tcnt_reg <= tcnt_reg + 5'h01;
      end
      case (state_reg)
        S_IDLE: begin
          if (cmd_fire) begin
            done_reg    <= 1'b0;
            intr_reg    <= 1'b0;
            illegal_reg <= !op_next.valid; // RL13
            if (op_next.valid) begin
              op_reg    <= op_next;
              dest_reg  <= hwdata[13:11];
              tcnt_reg  <= 5'h00;
              io_rd     <= 1'b1;
              io_addr   <= {b_reg, c_reg}; // RL2
              state_reg <= S_PORT;
            end
          end
        end
        S_PORT: begin
          if (io_ack) begin
            io_rd       <= 1'b0;
            in_byte_reg <= io_rdata; // RL3
            if (op_reg.reg_form) begin
              cont_reg   <= 1'b0;
              target_reg <= `T_IN_REG;
              state_reg  <= S_WAIT;
            end else begin
              state_reg <= S_PUSH;
            end
          end
        end
        S_PUSH: begin
          if (buf_in_ready) begin
            state_reg <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          // Counters move only once the byte is in memory
          if (buf_empty) begin
            state_reg <= S_UPD;
          end
        end
        S_UPD: begin
          cont_reg     <= cont_next;
          target_reg   <= cont_next ? `T_BLK_CONT : `T_BLK_LAST; // RL12
          ref_left_reg <= cont_next ? `REFRESH_COUNT : 2'h0; // RL10
          state_reg    <= S_WAIT;
        end
        S_WAIT: begin
          if (t_tick_reg && ref_left_reg != 2'h0) begin
            refresh      <= 1'b1; // RL10
            ref_left_reg <= ref_left_reg - 2'h1;
          end
          if (tcnt_reg >= target_reg && ref_left_reg == 2'h0) begin // RL12
            if (cont_reg && !irq_pending) begin
              tcnt_reg  <= 5'h00;
              io_rd     <= 1'b1;
              io_addr   <= {b_reg, c_reg}; // RL2
              state_reg <= S_PORT;
            end else begin
              // Last iteration done, or interrupt between iterations with PC already pointing back
              done_reg  <= 1'b1;
              intr_reg  <= cont_reg;
              irq_taken <= cont_reg; // RL10
              state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_PORT_ADDR: assert property ( // RL2
    io_rd |-> io_addr == {b_reg, c_reg})
    else $error("port address differs from count and port registers");

  AST_DEST_D: assert property ( // RL1
    state_reg == S_PORT && io_ack && op_reg.reg_form && dest_reg == `DEST_D
    |=> d_reg == $past(io_rdata))
    else $error("register input missed destination D");

  AST_FLAG_ONLY: assert property ( // RL5
    state_reg == S_PORT && io_ack && op_reg.reg_form && dest_reg == `DEST_FLAGS
    |=> {b_reg, c_reg, d_reg, e_reg, h_reg, l_reg, a_reg} ==
        $past({b_reg, c_reg, d_reg, e_reg, h_reg, l_reg, a_reg}))
    else $error("flag-only input wrote a register");

  AST_IN_FLAGS: assert property ( // RL4
    state_reg == S_PORT && io_ack && op_reg.reg_form
    |=> f_reg[`FLG_Z] == ($past(io_rdata) == 8'h00) && !f_reg[`FLG_N]
        && !f_reg[`FLG_H] && f_reg[`FLG_C] == $past(f_reg[`FLG_C]))
    else $error("register input flags wrong");

  AST_UP_STEP: assert property ( // RL6
    state_reg == S_UPD && op_reg.up
    |=> {h_reg, l_reg} == $past({h_reg, l_reg}) + 16'h0001 && b_reg == $past(b_dec))
    else $error("up form pointer or count wrong");

  AST_DOWN_STEP: assert property ( // RL7
    state_reg == S_UPD && !op_reg.up
    |=> {h_reg, l_reg} == $past({h_reg, l_reg}) - 16'h0001 && b_reg == $past(b_dec))
    else $error("down form pointer or count wrong");

  AST_SINGLE_Z: assert property ( // RL8
    state_reg == S_UPD && !op_reg.rep
    |=> f_reg[`FLG_Z] == ($past(b_reg) == 8'h01) && f_reg[`FLG_N]
        && f_reg[`FLG_C] == $past(f_reg[`FLG_C]))
    else $error("single block flags wrong");

  AST_REPEAT_PC: assert property ( // RL9
    state_reg == S_UPD && op_reg.rep && b_reg != 8'h01
    |=> pc_reg == $past(pc_reg) - 16'h0002 ##1 cont_reg)
    else $error("repeat did not move PC back");

  AST_ZERO_IS_256: assert property ( // RL11
    state_reg == S_UPD && op_reg.rep && b_reg == 8'h00 |=> cont_reg && b_reg == 8'hff)
    else $error("zero count ended the repeat");

  AST_REPEAT_END: assert property ( // RL14
    state_reg == S_UPD && op_reg.rep && b_reg == 8'h01
    |=> ##1 !cont_reg && f_reg[`FLG_Z] && f_reg[`FLG_N])
    else $error("finished repeat flags wrong");

  AST_ITER_TIME: assert property ( // RL12
    $rose(io_rd) && $past(state_reg) == S_WAIT |-> $past(tcnt_reg) >= `T_BLK_CONT)
    else $error("continuing iteration shorter than 21 T states");

  AST_REFRESH: assert property ( // RL10
    $past(state_reg) == S_WAIT && state_reg == S_PORT |-> $past(ref_left_reg) == 2'h0
    && $past(cont_reg))
    else $error("next iteration began before two refresh cycles");

endmodule // port_input_block_transfer

/* File: tb/port_mem_model.sv */
/*
  Port peripheral and memory on the far side of the port input block.
  Assumes requests are held until acknowledged; slow adds wait cycles.
*/
module port_mem_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic [7:0] next_byte,
  input  wire logic       io_rd,
  output logic            io_ack,
  output logic      [7:0] io_rdata,
  input  wire logic       mem_wr,
  output logic            mem_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_io;
  int wait_mem;

  // ------------------------------------------------------------
  // Answers
  // ------------------------------------------------------------
  // Bus shows the inverse when not driven
  assign io_rdata = io_ack ? next_byte : ~next_byte;
  always @(posedge sys_clk) begin
    io_ack  <= 1'b0;
    mem_ack <= 1'b0;
    if (rst) begin
      wait_io  <= 0;
      wait_mem <= 0;
    end else begin
      if (io_rd && !io_ack) begin
        if (wait_io >= (slow ? 3 : 0)) begin
          io_ack  <= 1'b1;
          wait_io <= 0;
        end else wait_io <= wait_io + 1;
      end
      if (mem_wr && !mem_ack) begin
        if (wait_mem >= (slow ? 4 : 0)) begin
          mem_ack  <= 1'b1;
          wait_mem <= 0;
        end else wait_mem <= wait_mem + 1;
      end
    end
  end
endmodule // port_mem_model

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the port input block, register and block forms.
  Assumes the far side model in port_mem_model and an AHB-Lite master here.
*/
`include "port_input_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, slow = 0;
  logic        irq_pending = 0, up = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, io_rd, io_ack, mem_wr, mem_ack, refresh, irq_taken, rd_q;
  logic [15:0] io_addr, mem_addr, ptr, pc;
  logic [7:0]  io_rdata, mem_wdata, next_byte = 8'h23, r [8], f, by;
  logic [7:0]  ops [4] = '{8'ha2, 8'haa, 8'hb2, 8'hba};
  logic [7:0]  cnt [4] = '{8'h01, 8'h05, 8'h03, 8'h00};
  logic [7:0]  in_q [$];
  int          num_errors = 0, samples_checked = 0, cyc = 0, last = 0;
  int          moved, refreshes, irqs, n;

  assign hready = hreadyout;
  always #5 sys_clk = ~sys_clk;

  port_input_block_transfer u_port_input_block_transfer (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata),
    .io_ack(io_ack), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .mem_ack(mem_ack), .refresh(refresh), .irq_pending(irq_pending), .irq_taken(irq_taken));
  port_mem_model u_port_mem_model (.sys_clk(sys_clk), .rst(rst), .slow(slow),
    .next_byte(next_byte), .io_rd(io_rd), .io_ack(io_ack), .io_rdata(io_rdata),
    .mem_wr(mem_wr), .mem_ack(mem_ack));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task check(logic [31:0] got, logic [31:0] exp, string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task ahb(logic wr, logic [31:0] a, logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task exec(logic [7:0] op);
    int k;
    moved = 0; refreshes = 0; irqs = 0; last = -1000;
    ahb(1, `OFS_BC, {16'h0, r[0], r[1]}); ahb(1, `OFS_DE, {16'h0, r[2], r[3]});
    ahb(1, `OFS_PTR, {16'h0, ptr}); ahb(1, `OFS_AF, {16'h0, r[7], r[6]});
    ahb(1, `OFS_PC, {16'h0, pc}); ahb(1, `OFS_CMD, {16'h0, op, `OP_PREFIX});
    k = 0;
    do begin ahb(0, `OFS_STATUS, 0); k++; end while (q[0] !== 1'b0 && k < 9000);
    if (q[0] !== 1'b0) num_errors++;
  endtask
  task verify(logic [7:0] m);
    ahb(0, `OFS_BC, 0); check(q, {16'h0, r[0], r[1]}, "bc");
    ahb(0, `OFS_DE, 0); check(q, {16'h0, r[2], r[3]}, "de");
    ahb(0, `OFS_PTR, 0); check(q, {16'h0, ptr}, "pointer");
    ahb(0, `OFS_AF, 0); check({q[15:8], q[7:0] & m}, {r[7], r[6] & m}, "af");
    ahb(0, `OFS_PC, 0); check(q, {16'h0, pc}, "pc");
  endtask
  task summarize;
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Monitor of the far side
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    rd_q <= io_rd;
    if (!rst && io_rd && !rd_q) begin
      check(io_addr, {r[0], r[1]}, "port address");
      if (cyc - last < `T_BLK_CONT) check(cyc - last, `T_BLK_CONT, "iteration gap");
      last = cyc;
    end
    if (!rst && io_rd && io_ack) begin
      in_q.push_back(io_rdata);
      next_byte <= lfsr_next(next_byte);
    end
    if (!rst && mem_wr && mem_ack) begin
      check(mem_addr, ptr, "mem addr");
      check(mem_wdata, in_q.pop_front(), "mem data");
      r[0] = r[0] - 8'h1;
      ptr = up ? ptr + 16'h1 : ptr - 16'h1;
      moved++;
    end
    if (refresh) refreshes++;
    if (irq_taken) irqs++;
  end

  initial begin
    #800000;
    num_errors++;
    summarize();
  end

  initial begin
    for (int i = 0; i < 8; i++) r[i] = 8'h10 * i[7:0] + 8'h1;
    ptr = 16'h1000; pc = 16'h2000;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    ahb(0, 32'h40, 0); check(q, 0, "unmapped");
    ahb(1, `OFS_CMD, {16'h0, 8'h00, `OP_PREFIX});
    ahb(0, `OFS_STATUS, 0); check(q[`ST_ILLEGAL], 1'b1, "illegal");
    for (int d = 0; d < 8; d++) begin
      exec(`OP_REG_VAL | {2'b00, d[2:0], 3'b000});
      check(q[`ST_DONE], 1'b1, "done");
      by = in_q.pop_front();
      if (d == 4) ptr[15:8] = by;
      else if (d == 5) ptr[7:0] = by;
      else if (d != 6) r[d] = by;
      f = r[6];
      f[7] = by[7]; f[6] = (by == 8'h0); f[4] = 1'b0; f[2] = ~^by; f[1] = 1'b0;
      r[6] = f;
      verify(8'hd7);
    end
    for (int j = 0; j < 4; j++) begin
      r[0] = cnt[j]; up = ~ops[j][3]; slow <= (j == 3);
      n = ops[j][4] ? (cnt[j] == 0 ? 256 : cnt[j]) : 1;
      exec(ops[j]);
      check(moved, n, "bytes moved");
      check(refreshes, 2 * (n - 1), "refresh count");
      if (ops[j][4]) pc = pc - 16'(2 * (n - 1));
      r[6][6] = ops[j][4] ? 1'b1 : (r[0] == 8'h0); r[6][1] = 1'b1;
      verify(8'h43);
    end
    slow <= 1'b0; irq_pending <= 1'b1; r[0] = 8'h04; up = 1'b1;
    exec(`OP_UP_REPEAT);
    check(q[`ST_INTR], 1'b1, "interrupted");
    check(irqs, 1, "irq taken");
    check(moved, 1, "bytes before irq");
    pc = pc - 16'h2;
    verify(8'h02);
    summarize();
  end
endmodule // tb_top
